// *** hw/bdc_cfg.svh ***
// Function
// - Fine code from code register bits 11:0
// - Coarse code from code register bits 17:12
// - Fast clock: code applies after ten cycles
// - Slow clock: code applies after one cycle
// - Waveform generator may supply the DAC codes
// - Switches from mode bit or switch register
// - Normal mode closes switches two and three
// - Diagnostic mode closes switches zero and four
// - Override bit five enables per-switch bits
// - Config bit six selects code source
`ifndef BDC_CFG_SVH
`define BDC_CFG_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define BDC_OFS_CODE      16'h2120
`define BDC_OFS_SWCTL     16'h2124
`define BDC_OFS_CONFIG    16'h2128
`define BDC_OFS_CLKSEL    16'h212c
`define BDC_OFS_STATUS    16'h2130

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BDC_RST_CODE      18'h00000
`define BDC_RST_SWCTL     6'h00
`define BDC_RST_CONFIG    7'h02
`define BDC_RST_CLKSEL    1'h0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BDC_FINE_HI       11
`define BDC_FINE_LO       0
`define BDC_COARSE_HI     17
`define BDC_COARSE_LO     12
`define BDC_CFG_SRC       6
`define BDC_CFG_DIAG      5
`define BDC_CFG_VZMUX     4
`define BDC_CFG_VBMUX     3
`define BDC_CFG_REFSEL    2
`define BDC_CFG_PWDN      1
`define BDC_SW_OVR        5
`define BDC_STAT_BUSY     18

// ----------------------------------------------------------------
// Update latency and switch patterns
// ----------------------------------------------------------------
`define BDC_LAT_FAST      4'ha
`define BDC_LAT_SLOW      4'h1
`define BDC_SW_NORMAL     5'h0c
`define BDC_SW_DIAG       5'h11
`define BDC_SW_OPEN       5'h00

`endif

// *** hw/bdc_pkg.sv ***
`include "bdc_cfg.svh"

package bdc_pkg;

   typedef enum logic {
      BDC_IDLE,
      BDC_WAIT
   } bdc_upd_state_t;

   typedef struct packed {
      bdc_upd_state_t state;
      logic [3:0]     cnt;
      logic [17:0]    code;
   } bdc_upd_t;

   typedef struct packed {
      logic [17:0] code_reg;
      logic [5:0]  swctl_reg;
      logic [6:0]  config_reg;
      logic        clksel_reg;
      logic [11:0] fine;
      logic [5:0]  coarse;
      logic [4:0]  sw;
      logic        pwdn;
      logic        refsel;
      logic        vzmux;
      logic        vbmux;
      logic        busy;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } bdc_top_t;

endpackage

// *** hw/bdc_update_delay.sv ***
`timescale 1ns/10ps
`include "bdc_cfg.svh"

module bdc_update_delay
   import bdc_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        reset_n_in,
   // Load request
   input  wire logic        load_in,
   input  wire logic        slow_in,
   input  wire logic [17:0] code_in,
   // Apply side
   output logic             apply_out,
   output logic [17:0]      code_out,
   output logic             busy_out
);

   bdc_upd_t s_q;
   bdc_upd_t s_d;

   always_comb begin
      s_d = s_q;
      apply_out = 1'b0;
      unique case (s_q.state)
         BDC_IDLE: begin
         end
         BDC_WAIT: begin
            s_d.cnt = s_q.cnt - 4'h1;
            if (s_q.cnt == `BDC_LAT_SLOW) begin
               apply_out = 1'b1;
               s_d.state = BDC_IDLE;
            end
         end
      endcase
      // Latest load restarts the wait with both fields
      if (load_in) begin
         s_d.state = BDC_WAIT;
         s_d.code  = code_in;
         s_d.cnt   = slow_in ? `BDC_LAT_SLOW : `BDC_LAT_FAST;
      end
   end

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s_q <= '{state: BDC_IDLE, cnt: 4'h0, code: `BDC_RST_CODE};
      end else begin
         s_q <= s_d;
      end
   end

   assign code_out = s_q.code;
   assign busy_out = (s_q.state == BDC_WAIT);

endmodule

// *** hw/bdc_switch_decode.sv ***
`timescale 1ns/10ps
`include "bdc_cfg.svh"

module bdc_switch_decode
   import bdc_pkg::*;
(
   // Control fields
   input  wire logic       pwdn_in,
   input  wire logic       diag_switch_mode_in,
   input  wire logic [5:0] swctl_in,
   // Switch closures, one per switch
   output logic [4:0]      switch_out
);

   logic [4:0] mode_pat;

   assign mode_pat = diag_switch_mode_in ? `BDC_SW_DIAG : `BDC_SW_NORMAL;

   genvar i;
   generate
      for (i = 0; i < 5; i++) begin : g_sw
         // Power-down opens every switch
         assign switch_out[i] = !pwdn_in &&
                                (swctl_in[`BDC_SW_OVR] ? swctl_in[i]
                                                       : mode_pat[i]);
      end
   endgenerate

endmodule

// *** hw/bdc_top.sv ***
`timescale 1ns/10ps
`include "bdc_cfg.svh"

module bdc_top
   import bdc_pkg::*;
#(
   parameter int ADDR_W = 16
)
(
   // Clock and reset
   input  wire logic              mclk_in,
   input  wire logic              reset_n_in,
   // APB slave
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [ADDR_W-1:0] paddr_in,
   input  wire logic [31:0]       pwdata_in,
   output logic [31:0]            prdata_out,
   output logic                   pready_out,
   output logic                   pslverr_out,
   // Waveform generator code source
   input  wire logic [17:0]       wavegen_code_in,
   input  wire logic              wavegen_valid_in,
   // DAC codes
   output logic [11:0]            fine_bias_output,
   output logic [5:0]             coarse_zero_output,
   // Output switches
   output logic [4:0]             output_switch_out,
   // DAC analog controls and update busy
   output logic                   dac_power_down_out,
   output logic                   ref_select_out,
   output logic                   vzero_mux_out,
   output logic                   vbias_mux_out,
   output logic                   update_busy_out
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   bdc_top_t s_q;
   bdc_top_t s_d;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic        access;
   logic        commit;
   logic        wr_commit;
   logic        hit_code;
   logic        hit_swctl;
   logic        hit_config;
   logic        hit_clksel;
   logic        hit_status;
   logic        mapped;

   assign access     = psel_in && penable_in && !s_q.pready;
   assign commit     = psel_in && penable_in && s_q.pready;
   assign wr_commit  = commit && pwrite_in && !s_q.pslverr;
   assign hit_code   = (paddr_in == ADDR_W'(`BDC_OFS_CODE));
   assign hit_swctl  = (paddr_in == ADDR_W'(`BDC_OFS_SWCTL));
   assign hit_config = (paddr_in == ADDR_W'(`BDC_OFS_CONFIG));
   assign hit_clksel = (paddr_in == ADDR_W'(`BDC_OFS_CLKSEL));
   assign hit_status = (paddr_in == ADDR_W'(`BDC_OFS_STATUS));
   assign mapped     = hit_code || hit_swctl || hit_config || hit_clksel || hit_status;

   // ----------------------------------------------------------------
   // Code source selection
   // ----------------------------------------------------------------
   logic        src_wavegen;
   logic        load;
   logic [17:0] load_code;
   logic        apply;
   logic [17:0] applied_code;
   logic        busy;

   assign src_wavegen = s_q.config_reg[`BDC_CFG_SRC];

   // Register write or generator sample starts an update
   always_comb begin
      load      = 1'b0;
      load_code = s_q.code_reg;
      if (src_wavegen) begin
         load      = wavegen_valid_in;
         load_code = wavegen_code_in;
      end else if (wr_commit && hit_code) begin
         load      = 1'b1;
         load_code = pwdata_in[17:0];
      end
   end

   // ----------------------------------------------------------------
   // Update latency
   // ----------------------------------------------------------------
   bdc_update_delay u_delay (
      .mclk_in    (mclk_in),
      .reset_n_in (reset_n_in),
      .load_in    (load),
      .slow_in    (s_q.clksel_reg),
      .code_in    (load_code),
      .apply_out  (apply),
      .code_out   (applied_code),
      .busy_out   (busy)
   );

   // ----------------------------------------------------------------
   // Switch network
   // ----------------------------------------------------------------
   logic [4:0] sw_next;
   logic [6:0] cfg_next;
   logic [5:0] swctl_next;

   assign cfg_next   = (wr_commit && hit_config) ? pwdata_in[6:0] : s_q.config_reg;
   assign swctl_next = (wr_commit && hit_swctl) ? pwdata_in[5:0] : s_q.swctl_reg;

   bdc_switch_decode u_switch (
      .pwdn_in             (cfg_next[`BDC_CFG_PWDN]),
      .diag_switch_mode_in (cfg_next[`BDC_CFG_DIAG]),
      .swctl_in            (swctl_next),
      .switch_out          (sw_next)
   );

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   logic [31:0] rd_data;

   always_comb begin
      rd_data = 32'h0000_0000;
      if (hit_code) begin
         rd_data[17:0] = s_q.code_reg;
      end else if (hit_swctl) begin
         rd_data[5:0] = s_q.swctl_reg;
      end else if (hit_config) begin
         rd_data[6:0] = s_q.config_reg;
      end else if (hit_clksel) begin
         rd_data[0] = s_q.clksel_reg;
      end else if (hit_status) begin
         rd_data[17:0]             = {s_q.coarse, s_q.fine};
         rd_data[`BDC_STAT_BUSY]   = busy;
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;

      // One wait state, then pready for exactly one cycle
      s_d.pready  = access;
      s_d.pslverr = access && !mapped;
      if (access) begin
         s_d.prdata = pwrite_in ? 32'h0000_0000 : rd_data;
      end

      // Register writes take effect at the completing edge
      if (wr_commit && hit_code) begin
         s_d.code_reg = pwdata_in[17:0];
      end
      s_d.swctl_reg  = swctl_next;
      s_d.config_reg = cfg_next;
      if (wr_commit && hit_clksel) begin
         s_d.clksel_reg = pwdata_in[0];
      end

      // Both fields move together when the wait expires
      if (apply) begin
         s_d.fine   = applied_code[`BDC_FINE_HI:`BDC_FINE_LO];
         s_d.coarse = applied_code[`BDC_COARSE_HI:`BDC_COARSE_LO];
      end

      s_d.sw     = sw_next;
      s_d.pwdn   = cfg_next[`BDC_CFG_PWDN];
      s_d.refsel = cfg_next[`BDC_CFG_REFSEL];
      s_d.vzmux  = cfg_next[`BDC_CFG_VZMUX];
      s_d.vbmux  = cfg_next[`BDC_CFG_VBMUX];
      s_d.busy   = load || (busy && !apply);
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s_q.code_reg   <= `BDC_RST_CODE;
         s_q.swctl_reg  <= `BDC_RST_SWCTL;
         s_q.config_reg <= `BDC_RST_CONFIG;
         s_q.clksel_reg <= `BDC_RST_CLKSEL;
         s_q.fine       <= 12'h000;
         s_q.coarse     <= 6'h00;
         s_q.sw         <= `BDC_SW_OPEN;
         s_q.pwdn       <= 1'b1;
         s_q.refsel     <= 1'b0;
         s_q.vzmux      <= 1'b0;
         s_q.vbmux      <= 1'b0;
         s_q.busy       <= 1'b0;
         s_q.prdata     <= 32'h0000_0000;
         s_q.pready     <= 1'b0;
         s_q.pslverr    <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata_out         = s_q.prdata;
   assign pready_out         = s_q.pready;
   assign pslverr_out        = s_q.pslverr;
   assign fine_bias_output   = s_q.fine;
   assign coarse_zero_output = s_q.coarse;
   assign output_switch_out  = s_q.sw;
   assign dac_power_down_out = s_q.pwdn;
   assign ref_select_out     = s_q.refsel;
   assign vzero_mux_out      = s_q.vzmux;
   assign vbias_mux_out      = s_q.vbmux;
   assign update_busy_out    = s_q.busy;

endmodule

// *** dv/bdc_checker.sv ***
`timescale 1ns/10ps
`include "bdc_cfg.svh"

module bdc_checker
#(
   parameter int ADDR_W = 16
)
(
   // Clock and reset
   input wire logic              mclk_in,
   input wire logic              reset_n_in,
   // Bus
   input wire logic              psel_in,
   input wire logic              penable_in,
   input wire logic              pwrite_in,
   input wire logic [ADDR_W-1:0] paddr_in,
   input wire logic [31:0]       pwdata_in,
   input wire logic              pready_out,
   // Codes and switches
   input wire logic [17:0]       wavegen_code_in,
   input wire logic              wavegen_valid_in,
   input wire logic [11:0]       fine_bias_output,
   input wire logic [5:0]        coarse_zero_output,
   input wire logic [4:0]        output_switch_out,
   input wire logic              update_busy_out
);
   // ----------------------------------------
   // Shadow of written registers
   // ----------------------------------------
   logic [17:0] code_q;
   logic [6:0]  cfg_q;
   logic [5:0]  sw_q;
   logic        slow_q;
   logic        wr;
   logic        wr_code;
   assign wr = psel_in && penable_in && pready_out && pwrite_in;
   assign wr_code = wr && paddr_in == `BDC_OFS_CODE && !cfg_q[6];
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         code_q <= 18'h0;
         cfg_q <= 7'h02;
         sw_q <= 6'h0;
         slow_q <= 1'h0;
      end else if (wr) begin
         case (paddr_in)
            `BDC_OFS_CODE:   code_q <= pwdata_in[17:0];
            `BDC_OFS_CONFIG: cfg_q <= pwdata_in[6:0];
            `BDC_OFS_SWCTL:  sw_q <= pwdata_in[5:0];
            `BDC_OFS_CLKSEL: slow_q <= pwdata_in[0];
            default:         slow_q <= slow_q;
         endcase
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!reset_n_in);
   sequence hold_s;
      (update_busy_out && $stable(fine_bias_output))[*8];
   endsequence
   apb_wait_a: assert property ($rose(penable_in) && psel_in |-> !pready_out ##1 pready_out)
      else $error("no single wait state");
   fast_hold_a: assert property (wr_code && !slow_q |=> hold_s)
      else $error("code moved early");
   fast_apply_a: assert property (wr_code && !slow_q |-> ##11
      fine_bias_output == code_q[11:0] && coarse_zero_output == code_q[17:12])
      else $error("fast code not applied");
   slow_apply_a: assert property (wr_code && slow_q |=> $stable(fine_bias_output) ##1
      fine_bias_output == code_q[11:0] && coarse_zero_output == code_q[17:12])
      else $error("slow code not applied");
   wave_src_a: assert property (wavegen_valid_in && cfg_q[6] && slow_q |-> ##2
      {coarse_zero_output, fine_bias_output} == $past(wavegen_code_in, 2))
      else $error("generator code not applied");
   normal_sw_a: assert property (!cfg_q[1] && !sw_q[5] && !cfg_q[5] |->
      output_switch_out == 5'h0c) else $error("normal switches wrong");
   diag_sw_a: assert property (!cfg_q[1] && !sw_q[5] && cfg_q[5] |->
      output_switch_out == 5'h11) else $error("diagnostic switches wrong");
   ovr_sw_a: assert property (!cfg_q[1] && sw_q[5] |-> output_switch_out == sw_q[4:0])
      else $error("override switches wrong");
endmodule

bind bdc_top bdc_checker #(.ADDR_W(ADDR_W)) u_chk (.mclk_in, .reset_n_in, .psel_in,
   .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .wavegen_code_in,
   .wavegen_valid_in, .fine_bias_output, .coarse_zero_output, .output_switch_out,
   .update_busy_out);

// *** dv/bias_dac_control_tb.sv ***
`timescale 1ns/10ps
`include "bdc_cfg.svh"

module bias_dac_control_tb;
   logic        mclk_in = 1'h0;
   logic        reset_n_in = 1'h0;
   logic        psel_in = 1'h0;
   logic        penable_in = 1'h0;
   logic        pwrite_in = 1'h0;
   logic [15:0] paddr_in = 16'h0;
   logic [31:0] pwdata_in = 32'h0;
   logic [17:0] wavegen_code_in = 18'h0;
   logic        wavegen_valid_in = 1'h0;
   logic [31:0] prdata_out;
   logic        pready_out;
   logic        pslverr_out;
   logic [11:0] fine_bias_output;
   logic [5:0]  coarse_zero_output;
   logic [4:0]  output_switch_out;
   logic        dac_power_down_out;
   logic        ref_select_out;
   logic        vzero_mux_out;
   logic        vbias_mux_out;
   logic        update_busy_out;
   logic [31:0] rd;
   logic        er;
   logic [17:0] cur = 18'h0;
   int          fails = 0;
   int          checks_done = 0;

   always #2 mclk_in = ~mclk_in;

   bdc_top DUT (.mclk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
      .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .wavegen_code_in,
      .wavegen_valid_in, .fine_bias_output, .coarse_zero_output, .output_switch_out,
      .dac_power_down_out, .ref_select_out, .vzero_mux_out, .vbias_mux_out,
      .update_busy_out);

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      checks_done++;
      if (got !== ex) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge mclk_in);
      psel_in <= 1'h1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge mclk_in);
      penable_in <= 1'h1;
      do begin
         @(posedge mclk_in);
         n++;
      end while (pready_out !== 1'h1);
      chk("wait states", 32'h2, n);
      rd = prdata_out;
      er = pslverr_out;
      psel_in <= 1'h0;
      penable_in <= 1'h0;
   endtask

   task automatic rdc(input string nm, input logic [15:0] a, input logic [31:0] ex);
      apb(1'h0, a, 32'h0);
      chk(nm, ex, rd);
   endtask

   // Host-side fine code compensation
   function automatic logic [17:0] comp(input logic [17:0] c);
      comp = c;
      if (c[11:0] < {c[17:12], 6'h00}) begin
         comp[11:0] = c[11:0] - 12'h001;
      end
   endfunction

   task automatic close_out;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_init;
      logic [15:0] ia [10] = '{16'h0908, 16'h0c08, 16'h21f0, 16'h0410, 16'h0a28,
                               16'h238c, 16'h0a04, 16'h0a04, 16'h0a00, 16'h22f0};
      logic [15:0] iv [10] = '{16'h02c9, 16'h206c, 16'h0010, 16'h02c9, 16'h0009,
                               16'h0104, 16'h4859, 16'hf27b, 16'h8009, 16'h0000};
      foreach (ia[i]) begin
         apb(1'h1, ia[i], {16'h0, iv[i]});
         chk("init slverr", 32'h1, {31'h0, er});
      end
   endtask

   task automatic t_reset;
      rdc("code", `BDC_OFS_CODE, 32'h0);
      rdc("swctl", `BDC_OFS_SWCTL, 32'h0);
      rdc("config", `BDC_OFS_CONFIG, 32'h2);
      chk("pwdn", 32'h1, {31'h0, dac_power_down_out});
      chk("sw", 32'h0, {27'h0, output_switch_out});
      rdc("unmapped", 16'h2134, 32'h0);
      chk("slverr", 32'h1, {31'h0, er});
   endtask

   task automatic t_switch;
      logic [4:0] pat [4] = '{5'h15, 5'h0a, 5'h1f, 5'h00};
      apb(1'h1, `BDC_OFS_CONFIG, 32'h0);
      @(negedge mclk_in);
      chk("sw normal", 32'h0c, {27'h0, output_switch_out});
      apb(1'h1, `BDC_OFS_CONFIG, 32'h20);
      @(negedge mclk_in);
      chk("sw diag", 32'h11, {27'h0, output_switch_out});
      foreach (pat[i]) begin
         apb(1'h1, `BDC_OFS_SWCTL, {26'h0, 1'h1, pat[i]});
         @(negedge mclk_in);
         chk("sw ovr", {27'h0, pat[i]}, {27'h0, output_switch_out});
      end
      apb(1'h1, `BDC_OFS_SWCTL, 32'h1f);
      @(negedge mclk_in);
      chk("sw mode", 32'h11, {27'h0, output_switch_out});
   endtask

   task automatic t_cfg;
      apb(1'h1, `BDC_OFS_CONFIG, 32'h1e);
      @(negedge mclk_in);
      chk("sw pwdn", 32'h0, {27'h0, output_switch_out});
      chk("pwdn", 32'h1, {31'h0, dac_power_down_out});
      chk("mux", 32'h7, {29'h0, vzero_mux_out, vbias_mux_out, ref_select_out});
      apb(1'h1, `BDC_OFS_CONFIG, 32'h0);
      @(negedge mclk_in);
      chk("mux off", 32'h0,
          {28'h0, dac_power_down_out, vzero_mux_out, vbias_mux_out, ref_select_out});
   endtask

   task automatic t_code(input logic slow, input logic [17:0] c);
      logic [17:0] w;
      w = comp(c);
      apb(1'h1, `BDC_OFS_CLKSEL, {31'h0, slow});
      apb(1'h1, `BDC_OFS_CODE, {14'h0, w});
      repeat (slow ? 0 : 9) @(posedge mclk_in);
      @(negedge mclk_in);
      chk("code held", {14'h0, cur}, {14'h0, coarse_zero_output, fine_bias_output});
      chk("busy", 32'h1, {31'h0, update_busy_out});
      @(posedge mclk_in);
      @(negedge mclk_in);
      chk("fine", {20'h0, w[11:0]}, {20'h0, fine_bias_output});
      chk("coarse", {26'h0, w[17:12]}, {26'h0, coarse_zero_output});
      cur = w;
      rdc("status", `BDC_OFS_STATUS, {14'h0, w});
      rdc("clksel", `BDC_OFS_CLKSEL, {31'h0, slow});
   endtask

   task automatic t_wave;
      apb(1'h1, `BDC_OFS_CLKSEL, 32'h1);
      apb(1'h1, `BDC_OFS_CONFIG, 32'h40);
      @(posedge mclk_in);
      wavegen_code_in <= 18'h2a555;
      wavegen_valid_in <= 1'h1;
      @(posedge mclk_in);
      wavegen_valid_in <= 1'h0;
      @(posedge mclk_in);
      @(negedge mclk_in);
      chk("wave", 32'h2a555, {14'h0, coarse_zero_output, fine_bias_output});
      apb(1'h1, `BDC_OFS_CODE, 32'h1);
      repeat (3) @(posedge mclk_in);
      chk("src", 32'h2a555, {14'h0, coarse_zero_output, fine_bias_output});
   endtask

   initial begin
      repeat (16) @(posedge mclk_in);
      reset_n_in <= 1'h1;
      t_init;
      t_reset;
      t_switch;
      t_cfg;
      t_code(1'h0, 18'h3f123);
      t_code(1'h1, 18'h01fff);
      t_wave;
      close_out;
   end

   initial begin
      #20000;
      fails++;
      close_out;
   end
endmodule
